// ### bench/pcmr_host_model.sv
/* Host processor model: Avalon-MM master making single-byte accesses.
   Assumes a slave that answers by dropping waitrequest. */
`timescale 1ns/10ps
`default_nettype none
module pcmr_host_model
    import pcmr_pkg::*;
(
    input  wire logic        clock_in,       // Bus clock
    output var pcmr_av_req_s req_out,        // Request to the slave
    input  wire logic [31:0] readdata_in,    // Read data
    input  wire logic        waitrequest_in  // Slave not ready
);
    bit held;  // Last access left its strobe up for a back-to-back follower
    // Bus idle from time zero
    initial req_out = '0;
    // One access, held until waitrequest is seen low; last=0 keeps the strobe
    // up so the next call follows at the very edge that answered this one
    task automatic xfer(input logic w, input logic [3:0] idx, input logic [7:0] d,
                        input logic last, output logic [7:0] q);
        if (!held)
        begin
            @(posedge clock_in);
        end
        req_out.address    <= {idx, 2'b00};       // Four-bit index
        req_out.read       <= ~w;
        req_out.write      <= w;
        req_out.writedata  <= {24'h000000, d};   // Eight-bit data
        req_out.byteenable <= 4'h1;
        do
        begin
            @(posedge clock_in);
        end
        while (waitrequest_in !== 1'b0);
        q = readdata_in[7:0];
        if (last)
        begin
            req_out.read  <= 1'b0;
            req_out.write <= 1'b0;
        end
        held = ~last;
    endtask : xfer
endmodule : pcmr_host_model
`default_nettype wire

// ### bench/pcmr_regbank_properties.sv
/* Port checks for the register bank.
   Assumes a bind to pcmr_regbank and a host that holds each request. */
`timescale 1ns/10ps
`default_nettype none
module pcmr_regbank_properties
    import pcmr_pkg::*;
(
    input wire logic             clock_in,
    input wire logic             rst_in,
    input wire pcmr_av_req_s     avs_req_in,
    input wire logic [31:0]      avs_readdata_out,
    input wire logic             avs_waitrequest_out,
    input wire logic [15:0][7:0] status_in,
    input wire logic [7:0]       alarm_src_in,
    input wire logic             sig_slot_in,
    input wire logic             alarm_interrupt_out,
    input wire logic             sig_marker_out,
    input wire logic             pcm24_mode_out,
    input wire logic [31:0][7:0] ctrl_out
);
    logic       rq;   // Request present
    logic       ans;  // Read answered
    logic       wok;  // Taken bank 0 mode write with the mode bit set
    logic [3:0] idx;  // Register index
    assign rq  = avs_req_in.read | avs_req_in.write;
    assign idx = avs_req_in.address[5:2];
    assign ans = avs_req_in.read & ~avs_waitrequest_out;
    assign wok = avs_req_in.write & ~avs_waitrequest_out & avs_req_in.byteenable[0]
               & (idx == IDX_MODE) & avs_req_in.writedata[MODE_PCM24_BIT]
               & ~ctrl_out[IDX_PARITY][PARITY_BANK_BIT];
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    property p_wait_one; rq && avs_waitrequest_out |=> !avs_waitrequest_out; endproperty
    a_wait_one: assert property (p_wait_one) else $error("late bus answer");
    property p_wait_new; rq && !avs_waitrequest_out ##1 rq |-> avs_waitrequest_out; endproperty
    a_wait_new: assert property (p_wait_new) else $error("new request not held");
    property p_reset; disable iff (1'b0) rst_in |=> !pcm24_mode_out && ctrl_out[IDX_IDLE] == 8'h54;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");
    property p_rd_hi; ans |-> avs_readdata_out[31:8] == 24'h000000; endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
    property p_pcm24; wok |=> pcm24_mode_out; endproperty
    a_pcm24: assert property (p_pcm24) else $error("mode bit ignored");
    property p_idle; wok && !pcm24_mode_out |=> ctrl_out[IDX_IDLE] == IDLE_PCM24; endproperty
    a_idle: assert property (p_idle) else $error("idle code not forced");
    property p_stat; ans && !ctrl_out[IDX_COMMON][COMMON_CTRL_RD_BIT] && idx == 4'h0
        |-> avs_readdata_out[7:0] == $past(status_in[0], 2); endproperty
    a_stat: assert property (p_stat) else $error("status read wrong");
    property p_crd; ans && ctrl_out[IDX_COMMON][COMMON_CTRL_RD_BIT] && idx == IDX_IDLE
        && !ctrl_out[IDX_PARITY][PARITY_BANK_BIT]
        |-> avs_readdata_out[7:0] == ctrl_out[IDX_IDLE];
    endproperty
    a_crd: assert property (p_crd) else $error("control read wrong");
    property p_marker; !$past(rst_in) |-> sig_marker_out ==
        ($past(sig_slot_in) && $past(ctrl_out[IDX_TX_CTRL0][TX_CTRL0_ISIG_BIT])); endproperty
    a_marker: assert property (p_marker) else $error("marker wrong");
    property p_irq_off; !$past(ctrl_out[IDX_COMMON][COMMON_ALARM_BIT], 1)
        && !$past(ctrl_out[IDX_COMMON][COMMON_ALARM_BIT], 2)
        |-> !alarm_interrupt_out; endproperty
    a_irq_off: assert property (p_irq_off) else $error("alarm while disabled");
    property p_irq_on; (ctrl_out[IDX_COMMON][COMMON_ALARM_BIT]
        && |(alarm_src_in & ctrl_out[IDX_MASK]))[*3] |=> alarm_interrupt_out; endproperty
    a_irq_on: assert property (p_irq_on) else $error("alarm missing");
endmodule : pcmr_regbank_properties
`default_nettype wire

// ### bench/tb_top.sv
/* Register bank testbench: reset contents, mode switch, reads, alarm.
   Assumes the host model drives the bus and a 250 MHz clock. */
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import pcmr_pkg::*;
;
    logic             clock_in, rst_in, av_wait, sig_slot, irq, marker, pcm24;
    pcmr_av_req_s     av_req;
    logic [31:0]      av_rdata;
    logic [15:0][7:0] status;
    logic [7:0]       alarm_src;
    logic [31:0][7:0] ctrl;
    int               failures, n_compared;
    logic [7:0]       q_a, q_b;
    initial
    begin
        clock_in = 1'b0;
        forever #2 clock_in = ~clock_in;
    end
    pcmr_regbank dut (.clock_in(clock_in), .rst_in(rst_in), .avs_req_in(av_req),
        .avs_readdata_out(av_rdata), .avs_waitrequest_out(av_wait), .status_in(status),
        .alarm_src_in(alarm_src), .sig_slot_in(sig_slot), .alarm_interrupt_out(irq),
        .sig_marker_out(marker), .pcm24_mode_out(pcm24), .ctrl_out(ctrl));
    pcmr_host_model host (.clock_in(clock_in), .req_out(av_req), .readdata_in(av_rdata),
        .waitrequest_in(av_wait));
    // Expected 24-channel start contents by slot
    function automatic logic [7:0] exp24(input int s);
        case (s)
            1: return 8'h10;
            5: return 8'h80;
            8: return 8'h20;
            10, 13: return 8'hFF;
            11: return 8'h40;
            21: return 8'h70;
            default: return 8'h00;
        endcase
    endfunction : exp24
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        logic [7:0] q;
        host.xfer(1'b1, idx, d, 1'b1, q);
    endtask : wr
    task automatic rd(input logic [3:0] idx, input logic [7:0] exp);
        logic [7:0] q;
        host.xfer(1'b0, idx, 8'h00, 1'b1, q);
        check(q, exp);
    endtask : rd
    task automatic rst_pulse;
        rst_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        rst_in <= 1'b0;
    endtask : rst_pulse
    task automatic results;
        if (failures == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results
    // Main sequence
    initial
    begin
        failures = 0;
        n_compared = 0;
        alarm_src <= 8'h00;
        sig_slot <= 1'b0;
        for (int i = 0; i < 16; i++)
            status[i] <= 8'hA0 + 8'(i);
        rst_pulse();
        check({7'h00, pcm24}, 8'h00);
        check(ctrl[IDX_IDLE], 8'h54);
        rd(4'h0, 8'hA0);
        rd(4'hB, 8'hAB);
        rd(4'hE, 8'h00);
        host.xfer(1'b0, 4'h1, 8'h00, 1'b0, q_a);
        host.xfer(1'b0, 4'h2, 8'h00, 1'b1, q_b);
        check(q_a, 8'hA1);
        check(q_b, 8'hA2);
        wr(IDX_MODE, 8'h10);
        @(posedge clock_in);
        check({7'h00, pcm24}, 8'h01);
        for (int s = 0; s < 32; s++)
            check(ctrl[s], exp24(s));
        rd(4'hB, 8'h00);
        wr(IDX_COMMON, 8'h20);
        rd(IDX_IDLE, 8'hFF);
        rd(IDX_SIG_STACK, 8'h00);
        wr(IDX_TX_CTRL0, 8'h20);
        rd(IDX_SIG_STACK, 8'hFF);
        rd(4'hE, 8'h00);
        wr(IDX_MASK, 8'h01);
        wr(IDX_COMMON, 8'hA0);
        alarm_src <= 8'h01;
        repeat (4) @(posedge clock_in);
        check({7'h00, irq}, 8'h01);
        alarm_src <= 8'h02;
        wr(IDX_LOOP, 8'h80);
        repeat (4) @(posedge clock_in);
        check({7'h00, irq}, 8'h00);
        sig_slot <= 1'b1;
        repeat (2) @(posedge clock_in);
        check({7'h00, marker}, 8'h01);
        sig_slot <= 1'b0;
        wr(IDX_PARITY, 8'h80);
        rd(4'h5, 8'h70);
        rd(4'hB, 8'h40);
        rst_pulse();
        wr(IDX_MODE, 8'h00);
        wr(IDX_MODE, 8'h10);
        @(posedge clock_in);
        check(ctrl[IDX_IDLE], 8'hFF);
        check(ctrl[8], 8'h30);
        status[0] <= 8'h5A;
        rd(4'h0, 8'h5A);
        results();
    end
    // Watchdog against a hung bus
    initial
    begin
        repeat (4000) @(posedge clock_in);
        failures++;
        results();
    end
endmodule : tb_top
bind pcmr_regbank pcmr_regbank_properties chk (.clock_in(clock_in), .rst_in(rst_in),
    .avs_req_in(avs_req_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .status_in(status_in),
    .alarm_src_in(alarm_src_in), .sig_slot_in(sig_slot_in),
    .alarm_interrupt_out(alarm_interrupt_out), .sig_marker_out(sig_marker_out),
    .pcm24_mode_out(pcm24_mode_out), .ctrl_out(ctrl_out));
`default_nettype wire

// ### logic/pcmr_pkg.sv
/*
 * Package for the PCM frame aligner register bank: register indices,
 * field positions, reset contents for both channel modes, bus carriers
 * and the register bank state.
 * Assumes a single 250 MHz clock and a word-indexed Avalon-MM slave.
 */
// Contract
// - 24-channel init sets mode register 10h
// - 24-channel init sets global control 40h
// - 24-channel init: tx FS/DL 00h, source 80h
// - 24-channel init sets rx control 0 20h
// - Signaling stack FFh, unreadable until internal signaling
// - 24-channel init: idle code FFh, banks zero
// - 24-channel init clears all clear channel banks
// - 24-channel init: extended 00h, additional config 70h
// - 24-channel init clears common control register
// - Eight-bit data, four-bit register address
// - 22/10 registers in 24, 19/11 in 30
// - Reset gives 30-channel; mode bit selects 24
// - Control write-only unless control read enabled
// - Status registers read-only, continuously updated
// - Eight maskable alarm sources drive alarm output
// - Signaling position markers usable as requests
// - Mode bit first after reset loads 24-channel set
// - Later switch to 24 forces idle FFh only
`default_nettype none

package pcmr_pkg;

    // ************************************************************
    // Widths and indices
    // ************************************************************
    localparam int DATA_W = 8;                   // Register data width
    localparam int IDX_W  = 4;                   // Register index width
    localparam int AV_ADDR_W = 6;                // Byte address width on the bus

    localparam logic [3:0] IDX_COMMON    = 4'h0; // common_control_reg
    localparam logic [3:0] IDX_MODE      = 4'h1; // Mode register
    localparam logic [3:0] IDX_PARITY    = 4'h2; // channel_parity_reg
    localparam logic [3:0] IDX_LOOP      = 4'h3; // Channel loop back
    localparam logic [3:0] IDX_TX_CTRL0  = 4'h6; // tx_control_0
    localparam logic [3:0] IDX_SIG_STACK = 4'hA; // tx_signaling_stack
    localparam logic [3:0] IDX_MASK      = 4'hC; // Alarm mask
    localparam logic [3:0] IDX_IDLE      = 4'hD; // Idle channel code

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int COMMON_ALARM_BIT   = 7;       // Alarm interrupt enable
    localparam int COMMON_CTRL_RD_BIT = 5;       // control_read_enable
    localparam int MODE_PCM24_BIT     = 4;       // pcm_mode_select
    localparam int PARITY_BANK_BIT    = 7;       // Bank switching
    localparam int LOOP_AIA_BIT       = 7;       // Alarm acknowledge
    localparam int TX_CTRL0_ISIG_BIT  = 5;       // Internal signaling enable

    localparam logic [7:0] IDLE_PCM24 = 8'hFF;   // Idle code forced on switch
    localparam logic [7:0] BYTE_ZERO  = 8'h00;   // Cleared byte

    // Valid control slots {bank1,bank0} and status slots per mode
    localparam logic [31:0] CTRL_MAP_30 = 32'h03C2_3FFF;
    localparam logic [31:0] CTRL_MAP_24 = 32'h01FE_3FFF;
    localparam logic [15:0] STAT_MAP_30 = 16'h0BFF;
    localparam logic [15:0] STAT_MAP_24 = 16'h03FF;

    // ************************************************************
    // Reset contents, slot = bank*16 + index
    // ************************************************************
    function automatic logic [7:0] pcmr_init_value(input logic pcm24, input logic [4:0] slot);
        logic [7:0] v;
        v = 8'h00;
        if (pcm24)
        begin
            unique case (slot)
                5'h01:   v = 8'h10;              // Mode register
                5'h05:   v = 8'h80;              // fs_dl_source_reg
                5'h08:   v = 8'h20;              // rx_control_0
                5'h0A:   v = 8'hFF;              // tx_signaling_stack
                5'h0B:   v = 8'h40;              // global_control_reg
                5'h0D:   v = 8'hFF;              // Idle channel code
                5'h15:   v = 8'h70;              // additional_config_reg
                default: v = 8'h00;              // Common, tx FS/DL, banks
            endcase
        end
        else
        begin
            unique case (slot)
                5'h02:   v = 8'h40;              // Parity check channel 0
                5'h04:   v = 8'h40;              // Transmit service word
                5'h08:   v = 8'h30;              // Receive control 0
                5'h0A:   v = 8'hFF;              // Signaling stack set to FFh
                5'h0D:   v = 8'h54;              // Idle channel code
                default: v = 8'h00;              // Everything else
            endcase
        end
        return v;
    endfunction : pcmr_init_value

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic [AV_ADDR_W-1:0] address;           // Byte address
        logic                 read;              // Read request
        logic                 write;             // Write request
        logic [31:0]          writedata;         // Write data
        logic [3:0]           byteenable;        // Byte lanes
    } pcmr_av_req_s;

    typedef struct packed {
        logic [31:0][7:0] ctrl;                  // Control registers, two banks
        logic [15:0][7:0] stat;                  // Sampled status registers
        logic             pcm24;                 // 24-channel mode active
        logic             fresh;                 // No write since reset
        logic             ack;                   // Bus answer cycle
        logic [31:0]      rdata;                 // Read data
        logic [7:0]       alarm;                 // Latched alarm sources
        logic             irq;                   // Alarm output
        logic             marker;                // Signaling marker output
    } pcmr_state_s;

endpackage : pcmr_pkg

`default_nettype wire

// ### logic/pcmr_regbank.sv
/*
 * Register bank of the PCM frame aligner: control registers with both
 * channel modes, sampled status registers, alarm output and signaling
 * marker, reached over an Avalon-MM slave with waitrequest.
 * Assumes status and alarm inputs are synchronous to clock_in, and that
 * the host writes the mode register first after reset.
 */
// The Avalon-MM register port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none

module pcmr_regbank
    import pcmr_pkg::*;
(
    input  wire logic               clock_in,             // 250 MHz clock
    input  wire logic               rst_in,               // Sync reset, high
    input  wire pcmr_av_req_s       avs_req_in,           // Avalon request
    output logic [31:0]             avs_readdata_out,     // Avalon read data
    output logic                    avs_waitrequest_out,  // Avalon wait
    input  wire logic [15:0][7:0]   status_in,            // Core status values
    input  wire logic [7:0]         alarm_src_in,         // Alarm source levels
    input  wire logic               sig_slot_in,          // Signaling bit slot
    output logic                    alarm_interrupt_out,  // Alarm output, high
    output logic                    sig_marker_out,       // Signaling marker
    output logic                    pcm24_mode_out,       // 24-channel mode
    output logic [31:0][7:0]        ctrl_out              // Control registers
);

    // ************************************************************
    // Declarations
    // ************************************************************
    pcmr_state_s r;                                       // Current state
    pcmr_state_s next_r;                                  // Next state

    logic [3:0]  idx;                                     // Register index
    logic        bank;                                    // Bank select
    logic [4:0]  slot;                                    // Control slot
    logic        req;                                     // Request pending
    logic        wr_go;                                   // Write takes effect
    logic        ctrl_ok;                                 // Control slot exists
    logic        stat_ok;                                 // Status slot exists
    logic [31:0] ctrl_map;                                // Control map of mode
    logic [15:0] stat_map;                                // Status map of mode
    logic [7:0]  wbyte;                                   // Written byte
    logic [7:0]  rbyte;                                   // Byte to read

    // ************************************************************
    // Address decode
    // ************************************************************
    // Word index from byte address; bank from the bank-switch bit
    always_comb
    begin
        idx      = avs_req_in.address[AV_ADDR_W-1:2];
        ctrl_map = r.pcm24 ? CTRL_MAP_24 : CTRL_MAP_30;
        // Only indices that own a bank 1 register switch; the others stay
        // reachable while switched, so the switch can be turned off again in 30-channel mode only
        bank     = r.ctrl[IDX_PARITY][PARITY_BANK_BIT] & ctrl_map[{1'b1, idx}];
        slot     = {bank, idx};
        req      = avs_req_in.read | avs_req_in.write;
        wr_go    = avs_req_in.write & r.ack & avs_req_in.byteenable[0];
        stat_map = r.pcm24 ? STAT_MAP_24 : STAT_MAP_30;
        ctrl_ok  = ctrl_map[slot];
        stat_ok  = stat_map[idx];
        wbyte    = avs_req_in.writedata[DATA_W-1:0];
    end

    // ************************************************************
    // Read data selection
    // ************************************************************
    // Status by default, control only in the read test mode
    always_comb
    begin
        rbyte = BYTE_ZERO;
        if (r.ctrl[IDX_COMMON][COMMON_CTRL_RD_BIT])
        begin
            if (ctrl_ok)
            begin
                rbyte = r.ctrl[slot];
            end
            if (slot == {1'b0, IDX_LOOP})
            begin
                rbyte[LOOP_AIA_BIT] = 1'b0;               // Acknowledge bit hidden
            end
            if (slot == {1'b0, IDX_SIG_STACK} && !r.ctrl[IDX_TX_CTRL0][TX_CTRL0_ISIG_BIT])
            begin
                rbyte = BYTE_ZERO;                        // Stack hidden
            end
        end
        else if (stat_ok)
        begin
            rbyte = r.stat[idx];
        end
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        next_r = r;

        // Status follows the core every cycle, never the host
        next_r.stat = status_in;

        // Bus answer one cycle after the request is seen
        next_r.ack = req & ~r.ack;
        if (req && !r.ack)
        begin
            next_r.rdata = {24'h00_0000, rbyte};
        end

        // Control writes, only on existing slots
        if (wr_go && ctrl_ok)
        begin
            if (slot == {1'b0, IDX_MODE} && wbyte[MODE_PCM24_BIT] && !r.pcm24)
            begin
                if (r.fresh)
                begin
                    // Mode bit first after reset: whole 24-channel set
                    for (int s = 0; s < 32; s++)
                    begin
                        next_r.ctrl[s] = pcmr_init_value(1'b1, 5'(s));
                    end
                end
                else
                begin
                    // Late switch: only the idle code changes
                    next_r.ctrl[IDX_IDLE] = IDLE_PCM24;
                end
                next_r.ctrl[IDX_MODE] = wbyte;
            end
            else
            begin
                next_r.ctrl[slot] = wbyte;
            end
            // Mode follows the written mode-select bit
            if (slot == {1'b0, IDX_MODE})
            begin
                next_r.pcm24 = wbyte[MODE_PCM24_BIT];
            end
        end
        if (wr_go)
        begin
            next_r.fresh = 1'b0;
        end

        // Alarm latch: set wins over acknowledge
        if (wr_go && ctrl_ok && slot == {1'b0, IDX_LOOP} && wbyte[LOOP_AIA_BIT])
        begin
            next_r.alarm = BYTE_ZERO;
        end
        next_r.alarm = next_r.alarm | (alarm_src_in & r.ctrl[IDX_MASK]);
        next_r.irq   = r.ctrl[IDX_COMMON][COMMON_ALARM_BIT] & (|r.alarm);

        // Signaling position marker, usable as interrupt or DMA request
        next_r.marker = sig_slot_in & r.ctrl[IDX_TX_CTRL0][TX_CTRL0_ISIG_BIT];

        // Reset gives the 30-channel set
        if (rst_in)
        begin
            for (int s = 0; s < 32; s++)
            begin
                next_r.ctrl[s] = pcmr_init_value(1'b0, 5'(s));
            end
            next_r.stat   = '0;
            next_r.pcm24  = 1'b0;
            next_r.fresh  = 1'b1;
            next_r.ack    = 1'b0;
            next_r.rdata  = '0;
            next_r.alarm  = BYTE_ZERO;
            next_r.irq    = 1'b0;
            next_r.marker = 1'b0;
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clock_in)
    begin
        r <= next_r;
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign avs_waitrequest_out = req & ~r.ack;            // Handshake, combinational
    assign avs_readdata_out    = r.rdata;                 // From flip-flops
    assign alarm_interrupt_out = r.irq;
    assign sig_marker_out      = r.marker;
    assign pcm24_mode_out      = r.pcm24;
    assign ctrl_out            = r.ctrl;

endmodule : pcmr_regbank

`default_nettype wire
